//--- include/psu_pkg.sv
`default_nettype none
package psu_pkg;
  // ---------------------------------------------------------------
  // register numbers on the device-control port
  // ---------------------------------------------------------------
  localparam logic [9:0] PSU_CTL_OFS = 10'h110;
  localparam logic [9:0] PSU_STS_OFS = 10'h111;
  localparam logic [9:0] PSU_HSIG_OFS = 10'h112;
  localparam logic [9:0] PSU_LSIG_OFS = 10'h113;
  localparam logic [9:0] PSU_CNT_OFS = 10'h114;
  localparam logic [9:0] PSU_HUPD_OFS = 10'h115;
  localparam logic [9:0] PSU_LUPD_OFS = 10'h116;
  // ---------------------------------------------------------------
  // field positions (bit 63 of the big-endian view is bit 0 here)
  // ---------------------------------------------------------------
  localparam int PSU_INIT_BIT = 0;
  localparam int PSU_WRITE_ACCUMULATE_ENABLE_BIT = 1;
  localparam int PSU_READ_ACCUMULATE_ENABLE_BIT = 2;
  localparam int PSU_COUNT_ENABLE_BIT = 5;
  localparam int PSU_TRANSFER_ERROR_FLAG_BIT = 0;
  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [31:0] PSU_MISR_TAPS = 32'hC000_0401;
  localparam logic [31:0] PSU_ZERO = 32'h0000_0000;
  localparam logic [2:0] PSU_CTL_RST = 3'h0;
  localparam logic PSU_TRANSFER_ERROR_FLAG_RST = 1'b0;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        priv;
    logic [9:0]  addr;
    logic [31:0] wdata;
  } psu_dcr_req_t;
  typedef struct packed {
    logic        valid;
    logic        err;
    logic [7:0]  strb;
    logic [63:0] data;
  } psu_beat_t;
endpackage
`default_nettype wire

//--- src/psu_signature_unit.sv
`timescale 1ns/1ps
`default_nettype none
module psu_signature_unit
  import psu_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  // device-control register port
  input  wire psu_dcr_req_t dcr_req_i,
  output logic              dcr_ack_o,
  output logic [31:0]       dcr_rdata_o,
  // data buses, one entry per terminating beat
  input  wire psu_beat_t    rd_beat_i,
  input  wire psu_beat_t    wr_beat_i,
  input  wire logic         debug_active_i
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] misr_step(input logic [31:0] cur,
                                            input logic [31:0] din);
    misr_step = {cur[30:0], 1'b0} ^ (cur[31] ? PSU_MISR_TAPS : PSU_ZERO)
                ^ din;
  endfunction

  function automatic logic [63:0] lane_mask(input logic [7:0] strb);
    logic [63:0] m;
    m = '0;
    for (int i = 0; i < 8; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    lane_mask = m;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic        cnt_en;
  logic        rd_en;
  logic        wr_en;
  logic        xfer_err;
  logic [31:0] high_sig;
  logic [31:0] low_sig;
  logic [31:0] beat_cnt;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire logic acc_ok = dcr_req_i.priv;
  wire logic wr_ok  = dcr_req_i.wr & acc_ok;
  wire logic rd_ok  = dcr_req_i.rd & acc_ok;
  wire logic [31:0] wd = dcr_req_i.wdata;

  wire logic wr_ctl  = wr_ok & (dcr_req_i.addr == PSU_CTL_OFS);
  wire logic wr_sts  = wr_ok & (dcr_req_i.addr == PSU_STS_OFS);
  wire logic wr_hsig = wr_ok & (dcr_req_i.addr == PSU_HSIG_OFS);
  wire logic wr_lsig = wr_ok & (dcr_req_i.addr == PSU_LSIG_OFS);
  wire logic wr_cnt  = wr_ok & (dcr_req_i.addr == PSU_CNT_OFS);
  wire logic wr_hupd = wr_ok & (dcr_req_i.addr == PSU_HUPD_OFS);
  wire logic wr_lupd = wr_ok & (dcr_req_i.addr == PSU_LUPD_OFS);
  wire logic do_init = wr_ctl & wd[PSU_INIT_BIT];

  // ---------------------------------------------------------------
  // beat qualification
  // ---------------------------------------------------------------
  wire logic rd_take = rd_beat_i.valid & rd_en & ~debug_active_i;
  wire logic wr_take = wr_beat_i.valid & wr_en & ~debug_active_i;

  // a failed read returns garbage, so zeros stand in for it
  wire logic [63:0] rd_word = rd_beat_i.err ? 64'h0 :
                              rd_beat_i.data & lane_mask(rd_beat_i.strb);
  // write data is the core's own, valid even when the slave errors
  wire logic [63:0] wr_word = wr_beat_i.data
                              & lane_mask(wr_beat_i.strb);

  // ---------------------------------------------------------------
  // signature chain: read, then write, then software update
  // ---------------------------------------------------------------
  wire logic [31:0] hi_a = rd_take ? misr_step(high_sig, rd_word[63:32])
                                   : high_sig;
  wire logic [31:0] hi_b = wr_take ? misr_step(hi_a, wr_word[63:32]) : hi_a;
  wire logic [31:0] hi_c = wr_hupd ? misr_step(hi_b, wd) : hi_b;
  wire logic [31:0] lo_a = rd_take ? misr_step(low_sig, rd_word[31:0])
                                   : low_sig;
  wire logic [31:0] lo_b = wr_take ? misr_step(lo_a, wr_word[31:0]) : lo_a;
  wire logic [31:0] lo_c = wr_lupd ? misr_step(lo_b, wd) : lo_b;

  wire logic [31:0] next_high_sig = do_init ? PSU_ZERO :
                                    wr_hsig ? wd : hi_c;
  wire logic [31:0] next_low_sig  = do_init ? PSU_ZERO :
                                    wr_lsig ? wd : lo_c;

  wire logic [1:0] cnt_inc = 2'(rd_take) + 2'(wr_take) + 2'(wr_lupd);
  wire logic [31:0] next_beat_cnt = do_init ? PSU_ZERO :
                                    wr_cnt  ? wd :
                                    cnt_en  ? beat_cnt + 32'(cnt_inc)
                                            : beat_cnt;

  // set wins over a simultaneous write-one clear
  wire logic err_set = rd_take & rd_beat_i.err;
  wire logic next_xfer_err = err_set |
                             (xfer_err & ~(wr_sts & wd[PSU_TRANSFER_ERROR_FLAG_BIT]));

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (dcr_req_i.addr)
      PSU_CTL_OFS: begin
        rd_mux[PSU_COUNT_ENABLE_BIT] = cnt_en;
        rd_mux[PSU_READ_ACCUMULATE_ENABLE_BIT]  = rd_en;
        rd_mux[PSU_WRITE_ACCUMULATE_ENABLE_BIT]  = wr_en;
      end
      PSU_STS_OFS:  rd_mux[PSU_TRANSFER_ERROR_FLAG_BIT] = xfer_err;
      PSU_HSIG_OFS: rd_mux = high_sig;
      PSU_LSIG_OFS: rd_mux = low_sig;
      PSU_CNT_OFS:  rd_mux = beat_cnt;
      default:      rd_mux = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // flops
  // ---------------------------------------------------------------
  // no reset here: contents must survive a system reset
  always_ff @(posedge core_clk_i) begin
    high_sig <= next_high_sig;
    low_sig  <= next_low_sig;
    beat_cnt <= next_beat_cnt;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {cnt_en, rd_en, wr_en} <= PSU_CTL_RST;
      xfer_err    <= PSU_TRANSFER_ERROR_FLAG_RST;
      dcr_ack_o   <= 1'b0;
      dcr_rdata_o <= PSU_ZERO;
    end else begin
      if (wr_ctl) begin
        cnt_en <= wd[PSU_COUNT_ENABLE_BIT];
        rd_en  <= wd[PSU_READ_ACCUMULATE_ENABLE_BIT];
        wr_en  <= wd[PSU_WRITE_ACCUMULATE_ENABLE_BIT];
      end
      xfer_err    <= next_xfer_err;
      dcr_ack_o   <= rd_ok | wr_ok;
      dcr_rdata_o <= rd_ok ? rd_mux : PSU_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  wire logic quiet = !rd_take && !wr_take && !wr_ok;

  sequence s_init_write;
    wr_ctl && wd[PSU_INIT_BIT];
  endsequence
  sequence s_all_zero;
    high_sig == 32'h0 && low_sig == 32'h0 && beat_cnt == 32'h0;
  endsequence

  property p_init_clears;
    @(posedge core_clk_i) disable iff (!rstn_i)
      s_init_write |=> s_all_zero;
  endproperty
  a_init_clears: assert property (p_init_clears)
    else $error("init did not clear signatures and counter");

  property p_ctl_reads;
    @(posedge core_clk_i) disable iff (!rstn_i)
      rd_ok && dcr_req_i.addr == PSU_CTL_OFS |=>
        dcr_rdata_o[PSU_INIT_BIT] == 1'b0 && dcr_rdata_o[31:6] == 26'h0
        && dcr_rdata_o[4:3] == 2'h0;
  endproperty
  a_ctl_reads: assert property (p_ctl_reads)
    else $error("control reserved or init bit read nonzero");

  property p_cnt_hold;
    @(posedge core_clk_i) disable iff (!rstn_i)
      !cnt_en && !wr_ok |=> $stable(beat_cnt);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold)
    else $error("counter moved while disabled");

  property p_lupd_counts;
    @(posedge core_clk_i) disable iff (!rstn_i)
      cnt_en && wr_lupd && !rd_take && !wr_take |=>
        beat_cnt == $past(beat_cnt) + 32'h1 &&
        low_sig == misr_step($past(low_sig), $past(wd));
  endproperty
  a_lupd_counts: assert property (p_lupd_counts)
    else $error("low update did not compress and count");

  property p_hupd;
    @(posedge core_clk_i) disable iff (!rstn_i)
      wr_hupd && !rd_take && !wr_take |=>
        high_sig == misr_step($past(high_sig), $past(wd)) &&
        beat_cnt == $past(beat_cnt);
  endproperty
  a_hupd: assert property (p_hupd)
    else $error("high update wrong or counted");

  property p_err_sets;
    @(posedge core_clk_i) disable iff (!rstn_i)
      rd_take && rd_beat_i.err |=> xfer_err ##1 xfer_err || $past(wr_sts);
  endproperty
  a_err_sets: assert property (p_err_sets)
    else $error("read error not flagged");

  property p_err_sticky;
    @(posedge core_clk_i) disable iff (!rstn_i)
      xfer_err && !(wr_sts && wd[PSU_TRANSFER_ERROR_FLAG_BIT]) |=> xfer_err;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error flag lost without a write of one");

  property p_wr_err_quiet;
    @(posedge core_clk_i) disable iff (!rstn_i)
      !xfer_err && !(rd_take && rd_beat_i.err) |=> !xfer_err;
  endproperty
  a_wr_err_quiet: assert property (p_wr_err_quiet)
    else $error("error flag set without a read error");

  property p_rd_ignored;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (!rd_en || debug_active_i) && !wr_take && !wr_ok |=>
        $stable(low_sig) && $stable(high_sig);
  endproperty
  a_rd_ignored: assert property (p_rd_ignored)
    else $error("signature moved with no qualified beat");

  property p_user_blocked;
    @(posedge core_clk_i) disable iff (!rstn_i)
      dcr_req_i.wr && !dcr_req_i.priv && quiet |=>
        $stable({cnt_en, rd_en, wr_en}) && $stable(low_sig) && $stable(high_sig)
        && !dcr_ack_o;
  endproperty
  a_user_blocked: assert property (p_user_blocked)
    else $error("user-mode access took effect");

  sequence s_lone_read_err;
    rd_take && rd_beat_i.err && !wr_take && !wr_ok;
  endsequence
  sequence s_lone_full_write;
    wr_take && wr_beat_i.strb == 8'hFF && !rd_take && !wr_ok;
  endsequence

  // an errored read must step with zeros, not the returned data
  property p_err_zeros;
    @(posedge core_clk_i) disable iff (!rstn_i)
      s_lone_read_err |=>
        high_sig == misr_step($past(high_sig), PSU_ZERO) &&
        low_sig == misr_step($past(low_sig), PSU_ZERO);
  endproperty
  a_err_zeros: assert property (p_err_zeros)
    else $error("errored read did not accumulate zeros");

  property p_wr_step;
    @(posedge core_clk_i) disable iff (!rstn_i)
      s_lone_full_write |=>
        high_sig == misr_step($past(high_sig), $past(wr_beat_i.data[63:32]))
        && low_sig == misr_step($past(low_sig), $past(wr_beat_i.data[31:0]));
  endproperty
  a_wr_step: assert property (p_wr_step)
    else $error("write beat not stepped into both signatures");

  property p_two_count;
    @(posedge core_clk_i) disable iff (!rstn_i)
      cnt_en && rd_take && wr_take && !wr_ok |=>
        beat_cnt == $past(beat_cnt) + 32'h2;
  endproperty
  a_two_count: assert property (p_two_count)
    else $error("two beats in one cycle not counted twice");

  property p_seed_load;
    @(posedge core_clk_i) disable iff (!rstn_i)
      wr_hsig |=> high_sig == $past(wd);
  endproperty
  a_seed_load: assert property (p_seed_load)
    else $error("high seed not loaded");

  property p_cnt_load;
    @(posedge core_clk_i) disable iff (!rstn_i)
      wr_cnt |=> beat_cnt == $past(wd);
  endproperty
  a_cnt_load: assert property (p_cnt_load)
    else $error("counter start value not loaded");

  property p_debug_freeze;
    @(posedge core_clk_i) disable iff (!rstn_i)
      debug_active_i && !wr_ok |=>
        $stable(high_sig) && $stable(low_sig) && $stable(beat_cnt)
        && $stable(xfer_err);
  endproperty
  a_debug_freeze: assert property (p_debug_freeze)
    else $error("state moved during a debug session");

  property p_priv_ack;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (dcr_req_i.rd || dcr_req_i.wr) && dcr_req_i.priv |=> dcr_ack_o;
  endproperty
  a_priv_ack: assert property (p_priv_ack)
    else $error("privileged access not acknowledged");

endmodule
`default_nettype wire

//--- tb/psu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module psu_bus_model
  import psu_pkg::*;
(
  // clock
  input  wire logic     core_clk_i,
  // terminating beats toward the unit
  output var psu_beat_t rd_beat_o,
  output var psu_beat_t wr_beat_o
);
  initial begin
    rd_beat_o = '0;
    wr_beat_o = '0;
  end
  // ---------------------------------------------------------------
  // one beat per bus, then idle
  // ---------------------------------------------------------------
  // idle lanes carry inverted data so a stale beat never looks valid
  task automatic beat(input psu_beat_t r, input psu_beat_t w);
    @(negedge core_clk_i);
    rd_beat_o <= r;
    wr_beat_o <= w;
    @(negedge core_clk_i);
    rd_beat_o <= '{1'b0, ~r.err, ~r.strb, ~r.data};
    wr_beat_o <= '{1'b0, ~w.err, ~w.strb, ~w.data};
  endtask
endmodule
`default_nettype wire

//--- tb/psu_signature_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module psu_signature_unit_tb_top
  import psu_pkg::*;
;
  logic         core_clk_i = 1'b0;
  logic         rstn_i;
  logic         dbg;
  psu_dcr_req_t req;
  logic         ack;
  logic [31:0]  q;
  logic         uk;
  logic [31:0]  uv;
  psu_beat_t    rb;
  psu_beat_t    wb;
  logic [31:0]  hs, ls, cnt;
  logic         transfer_error_flag, e_cnt, e_rd, e_wr;
  int           n_mismatch, samples_checked, cyc;
  localparam psu_beat_t NB = '0;
  psu_signature_unit dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .dcr_req_i(req),
    .dcr_ack_o(ack), .dcr_rdata_o(q), .rd_beat_i(rb), .wr_beat_i(wb),
    .debug_active_i(dbg));
  psu_bus_model bus (.core_clk_i(core_clk_i), .rd_beat_o(rb),
                     .wr_beat_o(wb));
  always #5 core_clk_i = ~core_clk_i;
  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  function automatic logic [31:0] misr(logic [31:0] c, logic [31:0] d);
    return {c[30:0], 1'b0} ^ (c[31] ? PSU_MISR_TAPS : PSU_ZERO) ^ d;
  endfunction
  task automatic apply(input psu_beat_t b, input logic is_rd);
    logic [63:0] d;
    for (int i = 0; i < 8; i++) d[8*i+:8] = b.strb[i] ? b.data[8*i+:8] : 8'h00;
    if (b.valid && (is_rd ? e_rd : e_wr) && !dbg) begin
      if (is_rd && b.err) d = '0;
      transfer_error_flag = transfer_error_flag | (is_rd & b.err);
      ls = misr(ls, d[31:0]);
      hs = misr(hs, d[63:32]);
      if (e_cnt) cnt = cnt + 32'h1;
    end
  endtask
  task automatic run(input psu_beat_t r, input psu_beat_t w);
    bus.beat(r, w);
    apply(r, 1'b1);
    apply(w, 1'b0);
  endtask
  // ---------------------------------------------------------------
  // register port access
  // ---------------------------------------------------------------
  task automatic dcr(input logic r, w, p, input logic [9:0] a,
                     input logic [31:0] d, output logic k,
                     output logic [31:0] v);
    req <= '{r, w, p, a, d};
    @(negedge core_clk_i);
    req <= '0;
    k = ack;
    v = q;
    @(negedge core_clk_i);
  endtask
  task automatic rdreg(input logic [9:0] a, input logic [31:0] e);
    logic k;
    logic [31:0] v;
    dcr(1'b1, 1'b0, 1'b1, a, 32'h0, k, v);
    `CHK("rd_ack", 1'b1, k)
    `CHK("rdata", e, v)
  endtask
  task automatic sw(input logic [9:0] a, input logic [31:0] d);
    logic k;
    logic [31:0] v;
    dcr(1'b0, 1'b1, 1'b1, a, d, k, v);
    `CHK("wr_ack", 1'b1, k)
    case (a)
      PSU_CTL_OFS: begin
        {e_cnt, e_rd, e_wr} = {d[5], d[2], d[1]};
        if (d[0]) {hs, ls, cnt} = '0;
      end
      PSU_STS_OFS: if (d[0]) transfer_error_flag = 1'b0;
      PSU_HSIG_OFS: hs = d;
      PSU_LSIG_OFS: ls = d;
      PSU_CNT_OFS: cnt = d;
      PSU_HUPD_OFS: hs = misr(hs, d);
      PSU_LUPD_OFS: begin
        ls = misr(ls, d);
        if (e_cnt) cnt = cnt + 32'h1;
      end
      default: ;
    endcase
  endtask
  task automatic check_all;
    rdreg(PSU_HSIG_OFS, hs);
    rdreg(PSU_LSIG_OFS, ls);
    rdreg(PSU_CNT_OFS, cnt);
    rdreg(PSU_STS_OFS, {31'h0, transfer_error_flag});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // about 170 cycles expected; well above that means a hang
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {rstn_i, dbg, req, transfer_error_flag, e_cnt, e_rd, e_wr} = '0;
    repeat (5) @(negedge core_clk_i);
    rstn_i = 1'b1;
    sw(PSU_CTL_OFS, 32'h0000_0001);
    rdreg(PSU_CTL_OFS, 32'h0);
    sw(PSU_CTL_OFS, 32'hFFFF_FFFF);
    rdreg(PSU_CTL_OFS, 32'h26);
    check_all;
    sw(PSU_HSIG_OFS, 32'h8123_4567);
    sw(PSU_LSIG_OFS, 32'hF0E1_D2C3);
    sw(PSU_CNT_OFS, 32'hFFFF_FFFE);
    check_all;
    $display("test setup done");
    run('{1, 0, 8'h0F, 64'hDEAD_BEEF_9ABC_DEF0}, NB);
    check_all;
    run('{1, 0, 8'hF0, 64'h1357_9BDF_0246_8ACE},
        '{1, 0, 8'hA5, 64'hCAFE_F00D_8899_AABB});
    check_all;
    run(NB, '{1, 1, 8'hFF, 64'h0F0F_0F0F_F0F0_F0F0});
    check_all;
    run('{1, 1, 8'hFF, 64'h7777_7777_7777_7777}, NB);
    check_all;
    $display("test beats done");
    sw(PSU_STS_OFS, 32'hFFFF_FFFE);
    check_all;
    run(NB, NB);
    sw(PSU_STS_OFS, 32'h1);
    check_all;
    sw(PSU_HUPD_OFS, 32'hA5A5_0001);
    check_all;
    sw(PSU_LUPD_OFS, 32'h5A5A_8000);
    check_all;
    rdreg(PSU_HUPD_OFS, 32'h0);
    rdreg(10'h3FF, 32'h0);
    dcr(1'b0, 1'b1, 1'b0, PSU_HSIG_OFS, 32'h0, uk, uv);
    `CHK("user_ack", 1'b0, uk)
    check_all;
    $display("test software done");
    dbg = 1'b1;
    run('{1, 0, 8'hFF, 64'h1}, '{1, 0, 8'hFF, 64'h2});
    dbg = 1'b0;
    check_all;
    sw(PSU_CTL_OFS, 32'h0);
    run('{1, 1, 8'hFF, 64'h3}, '{1, 0, 8'hFF, 64'h4});
    sw(PSU_LUPD_OFS, 32'h0000_0011);
    check_all;
    sw(PSU_CTL_OFS, 32'h26);
    run('{1, 1, 8'hFF, 64'h5}, NB);
    rstn_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    rstn_i = 1'b1;
    {transfer_error_flag, e_cnt, e_rd, e_wr} = '0;
    check_all;
    rdreg(PSU_CTL_OFS, 32'h0);
    $display("test reset done");
    print_verdict;
  end
endmodule
`default_nettype wire
